// *** hdl/lane_deskew_channel.sv ***
// Contract
// [RULE1] source stripes stream round-robin, earliest bit on lane n-1, latest lane 0
// [RULE2] each source lane passes a retiming stage before the link
// [RULE3] with inversion on, source inverts lane data through each odd element
// [RULE4] with inversion on, sink re-inverts data through each odd element
// [RULE5] reference channel copies one bit per lane, lane n-1 down to 0
// [RULE6] after four copied samples, one parity bit over them
// [RULE7] element order of even and odd depends on lane count
// [RULE8] reference frames follow back to back without gaps
// [RULE9] sink finds even and odd parity framing to place samples
// [RULE10] sink compares each lane with its reference sample to find delay
// [RULE11] alarm stays set while any lane has no match
// [RULE12] alarm clears only when all lanes matched with consistent skew
// [RULE13] after lock, measuring continues and alarm stays clear if consistent
// [RULE14] sink counts every reference versus lane mismatch as link error
// [RULE15] whole interface runs on the one recovered clock
// [RULE16] sink passes lanes through delay buffers absorbing lane offsets
// [RULE17] sink buffers carry each lane into the system timing domain
// [RULE18] reference copies are taken after inversion
// [RULE19] frame holds two to five five-bit elements in set order
// [RULE20] spare slots sample again from lane n-1 downward
// [RULE21] sink adjusts lane delay in whole bit steps to equalise
// [RULE22] even element parity makes ones even, odd element makes them odd
// [RULE23] lane count and buffer depth are named constants sized for skew
module lane_deskew_channel (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic inversion_enable,
    input wire logic [lane_deskew_pkg::LANES-1:0] src_stream_chunk,
    output logic [lane_deskew_pkg::LANES-1:0] tx_lane_bits,
    output logic tx_skew_ref_channel,
    input wire logic [lane_deskew_pkg::LANES-1:0] rx_lane_bits,
    input wire logic rx_skew_ref_channel,
    output logic [lane_deskew_pkg::LANES-1:0] sink_lane_bits,
    output logic sink_frame_locked,
    output logic out_of_alignment_alarm,
    output logic [lane_deskew_pkg::ERR_W-1:0] link_error_count
);
    localparam int N = lane_deskew_pkg::LANES;

    // reset release
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ---------------- source ----------------
    logic [N-1:0] lane_rt;
    logic [lane_deskew_pkg::ELEM_W-1:0] t_elem;
    logic [lane_deskew_pkg::POS_W-1:0] t_pos;
    logic t_acc;
    logic src_data_slot;
    wire t_elem_end = (t_pos == lane_deskew_pkg::POS_W'(lane_deskew_pkg::PARITY_POS));
    wire t_frame_end = t_elem_end &&
        (t_elem == lane_deskew_pkg::ELEM_W'(lane_deskew_pkg::ELEMS - 1));
    wire t_odd = lane_deskew_pkg::elem_is_odd(t_elem);
    wire src_inv = inversion_enable && t_odd;
    wire [N-1:0] src_word = lane_rt ^ {N{src_inv}};
    wire [lane_deskew_pkg::LANE_W-1:0] t_lane = lane_deskew_pkg::lane_of_slot(t_elem, t_pos);
    wire t_sample = src_word[t_lane];
    wire t_parity = t_acc ^ t_odd;
    wire next_ref = t_elem_end ? t_parity : t_sample;
    wire [lane_deskew_pkg::POS_W-1:0] next_t_pos = t_elem_end ? '0 : t_pos + 1'b1;
    wire [lane_deskew_pkg::ELEM_W-1:0] next_t_elem =
        t_frame_end ? '0 : (t_elem_end ? t_elem + 1'b1 : t_elem);

    // bit n-1 of each chunk is the earliest bit, so it lands on lane n-1
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lane_rt <= '0;
        end else begin
            lane_rt <= src_stream_chunk; // [RULE1] [RULE2]
        end
    end

    // frame position; wraps straight into the next frame
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            t_elem <= '0;
            t_pos <= '0;
        end else begin
            t_elem <= next_t_elem; // [RULE7] [RULE8] [RULE19]
            t_pos <= next_t_pos;
        end
    end

    // running xor of the four copied samples
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            t_acc <= 1'b0;
        end else if (t_pos == '0) begin
            t_acc <= t_sample; // [RULE22]
        end else begin
            t_acc <= t_acc ^ t_sample;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_lane_bits <= '0;
            tx_skew_ref_channel <= 1'b0;
            src_data_slot <= 1'b0;
        end else begin
            tx_lane_bits <= src_word; // [RULE3]
            tx_skew_ref_channel <= next_ref; // [RULE5] [RULE6] [RULE18] [RULE20]
            src_data_slot <= !t_elem_end;
        end
    end

    // ---------------- sink ----------------
    lane_hist_if hist_bus();
    lane_history u_hist (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .hist(hist_bus.store)
    );

    logic [lane_deskew_pkg::REF_DELAY-1:0] ref_dly;
    logic [3:0] win;
    logic [lane_deskew_pkg::ELEM_W-1:0] s_elem;
    logic [lane_deskew_pkg::POS_W-1:0] s_pos;
    lane_deskew_pkg::frame_state_e fstate;
    logic [lane_deskew_pkg::FRAME_CNT_W-1:0] good_cnt;
    logic [lane_deskew_pkg::FRAME_CNT_W-1:0] bad_cnt;
    logic [N-1:0][lane_deskew_pkg::TAP_W-1:0] skew;
    logic [N-1:0][lane_deskew_pkg::MATCH_W-1:0] match_cnt;
    logic [N-1:0] lane_locked;
    logic cmp_valid;
    logic cmp_ref;
    logic [lane_deskew_pkg::LANE_W-1:0] cmp_lane;
    logic out_inv;

    wire ref_now = ref_dly[lane_deskew_pkg::REF_DELAY-1];
    wire s_locked = (fstate == lane_deskew_pkg::FRAME_LOCKED);
    wire s_par_slot = (s_pos == lane_deskew_pkg::POS_W'(lane_deskew_pkg::PARITY_POS));
    wire s_odd = lane_deskew_pkg::elem_is_odd(s_elem);
    wire par_ok = ((^win) ^ ref_now) == s_odd;
    wire slip = !s_locked && s_par_slot && !par_ok;
    wire s_frame_end = s_par_slot &&
        (s_elem == lane_deskew_pkg::ELEM_W'(lane_deskew_pkg::ELEMS - 1));
    wire [lane_deskew_pkg::POS_W-1:0] next_s_pos = (s_par_slot && !slip) ? '0 :
                                                   (slip ? s_pos : s_pos + 1'b1);
    wire [lane_deskew_pkg::ELEM_W-1:0] next_s_elem = slip ? s_elem :
        (s_frame_end ? '0 : (s_par_slot ? s_elem + 1'b1 : s_elem));
    wire good_frame_par = s_par_slot && par_ok;
    wire bad_frame_par = s_par_slot && !par_ok;
    wire cmp_hit = (hist_bus.rd_word[cmp_lane] == cmp_ref);
    wire lane_err = cmp_valid && !cmp_hit;
    wire par_err = s_locked && bad_frame_par;
    wire [1:0] err_inc = {1'b0, lane_err} + {1'b0, par_err};
    wire [lane_deskew_pkg::ERR_W:0] err_sum = {1'b0, link_error_count} + {15'h0000, err_inc};
    wire [lane_deskew_pkg::ERR_W-1:0] next_err = err_sum[lane_deskew_pkg::ERR_W] ?
        lane_deskew_pkg::ERR_MAX : err_sum[lane_deskew_pkg::ERR_W-1:0];
    wire all_locked = s_locked && (&lane_locked);
    wire frame_good_last =
        good_cnt == lane_deskew_pkg::FRAME_CNT_W'(lane_deskew_pkg::FRAME_LOCK_GOOD - 1);
    wire frame_bad_last =
        bad_cnt == lane_deskew_pkg::FRAME_CNT_W'(lane_deskew_pkg::FRAME_LOSE_BAD - 1);

    always_comb begin
        for (int l = 0; l < N; l++) begin
            lane_locked[l] = (match_cnt[l] ==
                lane_deskew_pkg::MATCH_W'(lane_deskew_pkg::LANE_LOCK_MATCHES));
        end
    end

    // reference is held back so lanes may lead or lag it inside the buffer
    assign hist_bus.wr_word = rx_lane_bits; // [RULE16] [RULE17]
    assign hist_bus.taps = skew; // [RULE21]

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_dly <= '0;
            win <= 4'h0;
        end else begin
            ref_dly <= {ref_dly[lane_deskew_pkg::REF_DELAY-2:0], rx_skew_ref_channel}; // [RULE15]
            win <= {win[2:0], ref_now};
        end
    end

    // framing search: hold the position one bit while parity fails
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_elem <= '0;
            s_pos <= '0;
        end else begin
            s_elem <= next_s_elem; // [RULE9]
            s_pos <= next_s_pos;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fstate <= lane_deskew_pkg::FRAME_HUNT;
            good_cnt <= '0;
            bad_cnt <= '0;
        end else begin
            unique case (fstate)
                lane_deskew_pkg::FRAME_HUNT: begin
                    if (bad_frame_par) begin
                        good_cnt <= '0;
                    end else if (good_frame_par) begin
                        good_cnt <= good_cnt + 1'b1;
                    end
                    bad_cnt <= '0;
                    if (good_frame_par && frame_good_last) begin
                        fstate <= lane_deskew_pkg::FRAME_LOCKED; // [RULE9]
                    end
                end
                lane_deskew_pkg::FRAME_LOCKED: begin
                    good_cnt <= '0;
                    if (good_frame_par) begin
                        bad_cnt <= '0;
                    end else if (bad_frame_par) begin
                        bad_cnt <= bad_cnt + 1'b1;
                    end
                    if (bad_frame_par && frame_bad_last) begin
                        fstate <= lane_deskew_pkg::FRAME_HUNT;
                    end
                end
            endcase
        end
    end

    // compare stage lines up with the registered buffer read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_valid <= 1'b0;
            cmp_ref <= 1'b0;
            cmp_lane <= '0;
            out_inv <= 1'b0;
        end else begin
            cmp_valid <= s_locked && !s_par_slot;
            cmp_ref <= ref_now;
            cmp_lane <= lane_deskew_pkg::lane_of_slot(s_elem, s_pos);
            out_inv <= inversion_enable && s_locked && s_odd;
        end
    end

    // per-lane skew hunt: step one bit on a miss, count matches on a hit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            skew <= '0;
            match_cnt <= '0;
        end else if (!s_locked) begin
            match_cnt <= '0;
        end else if (cmp_valid && cmp_hit) begin
            if (!lane_locked[cmp_lane]) begin
                match_cnt[cmp_lane] <= match_cnt[cmp_lane] + 1'b1; // [RULE10] [RULE13]
            end
        end else if (cmp_valid) begin
            match_cnt[cmp_lane] <= '0; // [RULE10]
            skew[cmp_lane] <= skew[cmp_lane] + 1'b1; // [RULE21]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_of_alignment_alarm <= 1'b1;
            sink_frame_locked <= 1'b0;
            sink_lane_bits <= '0;
            link_error_count <= lane_deskew_pkg::ERR_RESET;
        end else begin
            out_of_alignment_alarm <= !all_locked; // [RULE11] [RULE12] [RULE13]
            sink_frame_locked <= s_locked;
            sink_lane_bits <= hist_bus.rd_word ^ {N{out_inv}}; // [RULE4]
            link_error_count <= next_err; // [RULE14]
        end
    end

    // ---------------- checks ----------------
    sequence src_parity_slot;
        !src_data_slot;
    endsequence

    chk_stripe_order: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE1]
        rst_n |-> ##2 tx_lane_bits == ($past(src_stream_chunk, 2) ^ {N{$past(src_inv)}}))
        else $error("lane data not striped in order");
    chk_lane_inversion: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE3]
        (inversion_enable && t_odd) |=> tx_lane_bits == ~$past(lane_rt))
        else $error("odd element data not inverted");
    chk_ref_copy: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE5]
        src_data_slot |-> tx_skew_ref_channel == $past(src_word[t_lane]))
        else $error("reference bit is not the lane copy");
    chk_ref_parity: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE6]
        src_parity_slot |-> (tx_skew_ref_channel ^ $past(tx_skew_ref_channel, 1)
            ^ $past(tx_skew_ref_channel, 2) ^ $past(tx_skew_ref_channel, 3)
            ^ $past(tx_skew_ref_channel, 4)) == $past(t_odd))
        else $error("reference parity wrong");
    chk_frame_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE8]
        t_frame_end |=> (t_elem == '0) && (t_pos == '0))
        else $error("frame did not restart at once");
    chk_alarm_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE11]
        (s_locked && !(&lane_locked)) |=> out_of_alignment_alarm [*1])
        else $error("alarm clear with an unlocked lane");
    chk_alarm_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE12]
        $fell(out_of_alignment_alarm) |-> $past(&lane_locked) && $past(s_locked))
        else $error("alarm cleared before all lanes matched");
    chk_error_count: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE14]
        (lane_err && link_error_count != lane_deskew_pkg::ERR_MAX)
            |=> link_error_count > $past(link_error_count))
        else $error("mismatch not counted");
    chk_skew_step: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE21]
        (s_locked && lane_err) |=> skew[$past(cmp_lane)] == $past(skew[cmp_lane]) + 1'b1)
        else $error("lane delay did not step");
endmodule

// *** hdl/lane_deskew_pkg.sv ***
package lane_deskew_pkg;
    localparam int LANES = 10;
    localparam int SAMPLES_PER_ELEM = 4;
    localparam int PARITY_POS = 4;
    localparam int ELEMS = ((LANES + 3) / 4 < 2) ? 2 : (LANES + 3) / 4;
    localparam int ELEM_W = 3;
    localparam int POS_W = 3;
    localparam int LANE_W = 4;
    localparam int HIST_DEPTH = 16;
    localparam int TAP_W = 4;
    localparam int REF_DELAY = 8;
    localparam int LANE_LOCK_MATCHES = 8;
    localparam int MATCH_W = 4;
    localparam int FRAME_LOCK_GOOD = 4;
    localparam int FRAME_LOSE_BAD = 4;
    localparam int FRAME_CNT_W = 3;
    localparam int ERR_W = 16;
    localparam logic [ERR_W-1:0] ERR_RESET = 16'h0000;
    localparam logic [ERR_W-1:0] ERR_MAX = 16'hffff;

    typedef enum logic [1:0] {
        FRAME_HUNT = 2'b01,
        FRAME_LOCKED = 2'b10
    } frame_state_e;

    // parity sense of a frame element for the fixed lane count
    function automatic logic elem_is_odd(input logic [ELEM_W-1:0] idx);
        logic odd;
        odd = 1'b0;
        case (ELEMS)
            2: odd = (idx == 3'h1);
            3: odd = (idx == 3'h2);
            4: odd = (idx >= 3'h2);
            default: odd = (idx == 3'h2) || (idx == 3'h4);
        endcase
        return odd;
    endfunction

    // lane sampled in a data slot: from n-1 downward, wrapping to n-1
    function automatic logic [LANE_W-1:0] lane_of_slot(input logic [ELEM_W-1:0] elem,
                                                       input logic [POS_W-1:0] pos);
        int slot;
        slot = int'(elem) * SAMPLES_PER_ELEM + int'(pos);
        return LANE_W'(LANES - 1 - (slot % LANES));
    endfunction
endpackage

// *** hdl/lane_hist_if.sv ***
interface lane_hist_if;
    logic [lane_deskew_pkg::LANES-1:0] wr_word;
    logic [lane_deskew_pkg::LANES-1:0][lane_deskew_pkg::TAP_W-1:0] taps;
    logic [lane_deskew_pkg::LANES-1:0] rd_word;
    modport store (input wr_word, input taps, output rd_word);
    modport user (output wr_word, output taps, input rd_word);
endinterface

// *** hdl/lane_history.sv ***
module lane_history (
    input wire logic sys_clk,
    input wire logic rst_n,
    lane_hist_if.store hist
);
    logic [lane_deskew_pkg::HIST_DEPTH-1:0][lane_deskew_pkg::LANES-1:0] mem; // [RULE23]

    // per-lane delay compensation: shift history, registered tap read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem <= '0;
            hist.rd_word <= '0;
        end else begin
            mem <= {mem[lane_deskew_pkg::HIST_DEPTH-2:0], hist.wr_word};
            for (int l = 0; l < lane_deskew_pkg::LANES; l++) begin
                hist.rd_word[l] <= mem[hist.taps[l]][l];
            end
        end
    end

    chk_hist_shift: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mem[1] == $past(mem[0])) else $error("history did not shift");
    chk_tap_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        hist.rd_word[0] == $past(mem[hist.taps[0]][0]))
        else $error("lane 0 tap read wrong");
endmodule

// *** dv/link_partner.sv ***
module link_partner (
    input wire logic sys_clk,
    input wire logic [lane_deskew_pkg::LANES-1:0] tx_lane_bits,
    input wire logic tx_skew_ref_channel,
    input wire logic [lane_deskew_pkg::LANES-1:0] flip_lane,
    output logic [lane_deskew_pkg::LANES-1:0] rx_lane_bits,
    output logic rx_skew_ref_channel
);
    timeunit 1ns;
    timeprecision 1ps;
    // looped link: lane i lags 1 + i mod 4 bit times, reference lags 2
    logic [3:0] lane_pipe [lane_deskew_pkg::LANES] = '{default: 4'h0};
    logic [1:0] ref_pipe = 2'h0;

    always @(posedge sys_clk) begin
        for (int i = 0; i < lane_deskew_pkg::LANES; i++) begin
            lane_pipe[i] <= {lane_pipe[i][2:0], tx_lane_bits[i] ^ flip_lane[i]};
        end
        ref_pipe <= {ref_pipe[0], tx_skew_ref_channel};
    end

    always_comb begin
        for (int i = 0; i < lane_deskew_pkg::LANES; i++) begin
            rx_lane_bits[i] = lane_pipe[i][i % 4];
        end
        rx_skew_ref_channel = ref_pipe[1];
    end
endmodule

// *** dv/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = lane_deskew_pkg::LANES;
    localparam int W = lane_deskew_pkg::ERR_W;
    // source two, link reference two, reference hold, buffer read and output two
    localparam int SINK_LAT = 2 + 2 + lane_deskew_pkg::REF_DELAY + 2;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic inversion_enable = 1'b0;
    logic [N-1:0] src_stream_chunk = 10'h000;
    logic [N-1:0] flip_lane = 10'h000;
    logic [N-1:0] tx_lane_bits;
    logic [N-1:0] rx_lane_bits;
    logic [N-1:0] sink_lane_bits;
    logic tx_skew_ref_channel;
    logic rx_skew_ref_channel;
    logic sink_frame_locked;
    logic out_of_alignment_alarm;
    logic [W-1:0] link_error_count;
    logic [15:0] lfsr = 16'hace1;
    logic [N-1:0] hist [128];
    logic [N-1:0] tl [60];
    logic [N-1:0] xl [60];
    logic tr [60];
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int n = 0;
    int fp = 0;
    int fl = 0;

    lane_deskew_channel lane_deskew_channel_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .inversion_enable(inversion_enable),
        .src_stream_chunk(src_stream_chunk), .tx_lane_bits(tx_lane_bits),
        .tx_skew_ref_channel(tx_skew_ref_channel), .rx_lane_bits(rx_lane_bits),
        .rx_skew_ref_channel(rx_skew_ref_channel), .sink_lane_bits(sink_lane_bits),
        .sink_frame_locked(sink_frame_locked),
        .out_of_alignment_alarm(out_of_alignment_alarm),
        .link_error_count(link_error_count)
    );

    link_partner link_partner_i (
        .sys_clk(sys_clk), .tx_lane_bits(tx_lane_bits),
        .tx_skew_ref_channel(tx_skew_ref_channel), .flip_lane(flip_lane),
        .rx_lane_bits(rx_lane_bits), .rx_skew_ref_channel(rx_skew_ref_channel)
    );

    always #4 sys_clk = ~sys_clk;

    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        errors++;
        $display("Error at %0t: %s", $time, msg);
    endtask

    task automatic chk_vec(input logic [N-1:0] got, input logic [N-1:0] exp, input string msg);
        total_checks++;
        if (got !== exp) fail(msg);
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        total_checks++;
        if (got !== exp) fail(msg);
    endtask

    task automatic chk_cnt(input logic [W-1:0] got, input logic [W-1:0] exp, input string msg);
        total_checks++;
        if (got !== exp) fail(msg);
    endtask

    // lock and relock are each allowed 20000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            fail("timeout");
            stop_test();
        end
    end

    // one falling edge: drive the next scrambled chunk and remember it
    task automatic step;
        @(negedge sys_clk);
        n++;
        for (int i = 0; i < 10; i++) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
        src_stream_chunk = lfsr[9:0];
        hist[n % 128] = lfsr[9:0];
    endtask

    task automatic record;
        for (int j = 0; j < 60; j++) begin
            step();
            tl[j] = tx_lane_bits;
            tr[j] = tx_skew_ref_channel;
            xl[j] = tx_lane_bits ^ hist[(n - 2) % 128];
        end
    endtask

    // frame of three five-bit elements: even, even, odd
    function automatic bit frame_ok(input int p, input int l);
        int q;
        int k;
        for (int j = 5; j < 59; j++) begin
            q = (j - p + 15) % 15;
            k = (q / 5) * 4 + q % 5;
            if (q % 5 < 4) begin
                if (tr[j] !== tl[j - l][N - 1 - k % N]) return 0;
            end else if (tr[j] !== (tr[j-1] ^ tr[j-2] ^ tr[j-3] ^ tr[j-4] ^ (q / 5 == 2))) begin
                return 0;
            end
        end
        return 1;
    endfunction

    task automatic find_frame;
        bit found;
        found = 0;
        for (int p = 0; p < 15; p++) begin
            for (int l = -1; l < 2; l++) begin
                if (!found && frame_ok(p, l)) begin
                    found = 1;
                    fp = p;
                    fl = l;
                end
            end
        end
        chk_bit(found, 1'b1, "reference frame layout");
    endtask

    task automatic wait_clear;
        for (int i = 0; i < 20000 && out_of_alignment_alarm !== 1'b0; i++) begin
            step();
        end
    endtask

    task automatic test_reset;
        repeat (4) @(negedge sys_clk);
        chk_vec(tx_lane_bits, 10'h000, "lanes in reset");
        chk_vec(sink_lane_bits, 10'h000, "sink data in reset");
        chk_bit(tx_skew_ref_channel, 1'b0, "reference in reset");
        chk_bit(sink_frame_locked, 1'b0, "lock in reset");
        chk_bit(out_of_alignment_alarm, 1'b1, "alarm in reset");
        chk_cnt(link_error_count, 16'h0000, "count in reset");
        @(negedge sys_clk);
        arst_n = 1'b1;
    endtask

    task automatic test_stripe;
        repeat (6) step();
        repeat (30) begin
            step();
            chk_vec(tx_lane_bits, hist[(n - 2) % 128], "lane striping");
        end
    endtask

    task automatic test_frame;
        record();
        find_frame();
    endtask

    task automatic test_invert;
        int q;
        inversion_enable = 1'b1;
        repeat (20) step();
        record();
        find_frame();
        for (int j = 5; j < 59; j++) begin
            q = (j + fl - fp + 30) % 15;
            chk_vec(xl[j], (q >= 10) ? 10'h3ff : 10'h000, "odd element inversion");
        end
    endtask

    task automatic test_lock;
        logic [W-1:0] c0;
        logic [N-1:0] exp_word;
        wait_clear();
        chk_bit(out_of_alignment_alarm, 1'b0, "alarm after lock");
        chk_bit(sink_frame_locked, 1'b1, "frame lock");
        repeat (5) step();
        c0 = link_error_count;
        repeat (200) begin
            step();
            exp_word = hist[(n - SINK_LAT) % 128];
            chk_vec(sink_lane_bits, exp_word, "deskewed data");
            chk_bit(out_of_alignment_alarm, 1'b0, "alarm held clear");
        end
        chk_cnt(link_error_count, c0, "clean link counts nothing");
    endtask

    task automatic test_errors;
        logic seen;
        logic [W-1:0] c0;
        seen = 1'b0;
        c0 = link_error_count;
        flip_lane = 10'h008;
        repeat (40) begin
            step();
            if (out_of_alignment_alarm === 1'b1) seen = 1'b1;
        end
        flip_lane = 10'h000;
        chk_bit(seen, 1'b1, "alarm on lane fault");
        chk_bit(link_error_count > c0, 1'b1, "lane errors counted");
        wait_clear();
        chk_bit(out_of_alignment_alarm, 1'b0, "relock after fault");
    endtask

    initial begin
        test_reset();
        test_stripe();
        test_frame();
        test_invert();
        test_lock();
        test_errors();
        stop_test();
    end
endmodule
